// File: rtl/rtcia_pkg.sv
// Contract
// - Timebase comes from the 32.768 kHz crystal tick; time registers run from it.
// - Nominal and temperature trim both correct the crystal rate.
// - The clock keeps running in every power saving mode.
// - Counters survive watchdog and pin resets; only power-on reset clears them.
// - Indirect reads need no key; indirect writes are key protected.
// - Writing the pointer address selects target register and read or write.
// - Hundredths through year update on crystal ticks.
// - Config and interval value writes take effect within two 128 Hz ticks.
// - Write select set copies pointer data into the addressed register.
// - Core loads key 0xEA first; without it the write is dropped.
// - Key clears to zero after each accepted indirect write.
// - Write select clear copies the addressed register into pointer data.
// - Alarm flag bit 6 sets on match of enabled alarms; software clears.
// - Interval flag bit 2 sets when interval elapses; software clears.
// - One-shot clear: flag after each interval, next interval starts at once.
// - One-shot set: flag only once after a single interval.
// - Interval enable clear stops timer and resets its 8-bit counter.
// - Pointer bit 7 is write select, bits 4:0 address, bits 6:5 reserved.
// - Alarm enable bits 4:0 gate date, weekday, hour, minute, second compare.
package rtcia_pkg;
   // Direct register addresses
   localparam logic [7:0] ADDR_CONFIG = 8'ha1;
   localparam logic [7:0] ADDR_ALARM_EN = 8'ha2;
   localparam logic [7:0] ADDR_PTR = 8'ha3;
   localparam logic [7:0] ADDR_PTR_DATA = 8'ha4;
   localparam logic [7:0] ADDR_KEY = 8'hc1;
   localparam logic [7:0] ADDR_NOM_TRIM = 8'hf6;
   localparam logic [7:0] ADDR_TEMP_TRIM = 8'hf7;
   // Config field positions
   localparam int CFG_ALARM_FLAG = 6;
   localparam int CFG_TB_HI = 5;
   localparam int CFG_TB_LO = 4;
   localparam int CFG_ONE_SHOT = 3;
   localparam int CFG_INT_FLAG = 2;
   localparam int CFG_IT_EN = 1;
   // Pointer field positions
   localparam int PTR_WRITE_SELECT = 7;
   localparam int PTR_ADDR_HI = 4;
   // Indirect register addresses
   localparam logic [4:0] IA_HTH = 5'h01;
   localparam logic [4:0] IA_SEC = 5'h02;
   localparam logic [4:0] IA_MIN = 5'h03;
   localparam logic [4:0] IA_HOUR = 5'h04;
   localparam logic [4:0] IA_DAY = 5'h05;
   localparam logic [4:0] IA_DATE = 5'h06;
   localparam logic [4:0] IA_MONTH = 5'h07;
   localparam logic [4:0] IA_YEAR = 5'h08;
   localparam logic [4:0] IA_INTERVAL_LENGTH_VALUE = 5'h09;
   localparam logic [4:0] IA_AL_SEC = 5'h0a;
   localparam logic [4:0] IA_AL_MIN = 5'h0b;
   localparam logic [4:0] IA_AL_HOUR = 5'h0c;
   localparam logic [4:0] IA_AL_DAY = 5'h0d;
   localparam logic [4:0] IA_AL_DATE = 5'h0e;
   // Key and reset values
   localparam logic [7:0] WRITE_KEY = 8'hea;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_DATE = 8'h01;
   localparam logic [7:0] RST_MONTH = 8'h01;
   // Calendar limits
   localparam logic [7:0] MAX_HTH = 8'h63;
   localparam logic [7:0] MAX_SEC = 8'h3b;
   localparam logic [7:0] MAX_HOUR = 8'h17;
   localparam logic [7:0] MAX_DAY = 8'h06;
   localparam logic [7:0] MAX_MONTH = 8'h0c;
   localparam logic [7:0] MAX_YEAR = 8'h63;
   // Timing
   localparam int XTAL_HZ = 32768;
   localparam int TICK_HZ = 128;
   localparam logic [7:0] TICK128_LAST = 8'((XTAL_HZ / TICK_HZ) - 1);
   localparam logic [16:0] HTH_STEP = 17'h00064;
   localparam logic [16:0] ACC_WRAP = 17'h08000;
   localparam logic [1:0] CFG_MAX_TICKS = 2'h2;
endpackage

// File: rtl/rtcia_prescaler.sv
`timescale 1ns/100ps
module rtcia_prescaler
   import rtcia_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Crystal tick and trim
   input wire logic xtalTick,
   input wire logic [8:0] trimSum,
   // Derived enables
   output logic tick128,
   output logic hthTick
);
   typedef struct packed {
      logic [7:0] div;
      logic [14:0] acc;
      logic t128;
      logic hth;
      logic [8:0] chkCount;
   } rtcia_pre_t;

   rtcia_pre_t s_reg, s_next;
   logic signed [17:0] sum;

   always_comb begin
      s_next = s_reg;
      s_next.t128 = 1'b0;
      s_next.hth = 1'b0;
      sum = 18'sd0;
      if (tick128) begin
         s_next.chkCount = 9'h000;
      end
      if (xtalTick) begin
         s_next.div = s_reg.div + 8'h01;
         s_next.chkCount = (tick128 ? 9'h000 : s_reg.chkCount) + 9'h001;
         s_next.t128 = (s_reg.div == TICK128_LAST);
         sum = $signed({3'b000, s_reg.acc}) + $signed({1'b0, HTH_STEP});
         if (s_reg.div == TICK128_LAST) begin
            sum = sum + 18'($signed(trimSum));
         end
         if (sum >= $signed({1'b0, ACC_WRAP})) begin
            s_next.hth = 1'b1;
            s_next.acc = 15'(sum - $signed({1'b0, ACC_WRAP}));
         end else if (sum < 18'sd0) begin
            s_next.acc = 15'h0000;
         end else begin
            s_next.acc = 15'(sum);
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick128 = s_reg.t128;
   assign hthTick = s_reg.hth;

   property p_tick128Period;
      @(posedge clk) disable iff (rst)
      tick128 && $past(tick128 == 1'b0) && (s_reg.chkCount != 9'h000) |->
         s_reg.chkCount == 9'h100;
   endproperty
   a_tick128Period: assert property (p_tick128Period) else $error("128 Hz period wrong");

   property p_hthFromTick;
      @(posedge clk) disable iff (rst)
      hthTick |-> $past(xtalTick);
   endproperty
   a_hthFromTick: assert property (p_hthFromTick) else $error("hundredth without tick");
endmodule // rtcia_prescaler

// File: rtl/rtcia_core.sv
`timescale 1ns/100ps
module rtcia_core
   import rtcia_pkg::*;
(
   // Clock, power-on reset and system reset
   input wire logic clk,
   input wire logic rst,
   input wire logic sysReset,
   // Crystal tick, one cycle per 32.768 kHz period
   input wire logic xtalTick,
   // Special function register access
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWrData,
   input wire logic sfrWr,
   input wire logic sfrRd,
   output logic [7:0] sfrRdData,
   // Temperature trim value from the calibration source
   input wire logic [7:0] tempTrimIn,
   // Interrupt enables and request
   input wire logic alarmIrqEnable,
   input wire logic intervalIrqEnable,
   output logic rtcIrq
);
   typedef struct packed {
      logic [7:0] cfgSfr;
      logic cfgPend;
      logic [4:0] alEnSfr;
      logic alEnPend;
      logic [7:0] intvalSfr;
      logic intvalPend;
      logic [1:0] timebase;
      logic oneShot;
      logic interval_timer_enable;
      logic [4:0] alEn;
      logic [7:0] interval_length_value;
      logic alarmFlag;
      logic intFlag;
      logic [7:0] itCount;
      logic itDone;
      logic [7:0] ptr;
      logic [7:0] dat;
      logic [7:0] key;
      logic [7:0] nomTrim;
      logic [7:0] hth, sec, min, hour, day, date, month, year;
      logic [7:0] alSec, alMin, alHour, alDay, alDate;
      logic chk;
      logic [7:0] rdData;
   } rtcia_state_t;

   rtcia_state_t s_reg, s_next;
   logic tick128, hthTick;
   logic secCarry, minCarry, hourCarry, tbTick, alarmMatch;
   logic ptrWrite, indWrite;
   logic [4:0] ptrAddr;

   function automatic logic [7:0] days_in_month(input logic [7:0] m, input logic [7:0] y);
      unique case (m)
         8'h04, 8'h06, 8'h09, 8'h0b: days_in_month = 8'h1e;
         8'h02: days_in_month = (y[1:0] == 2'b00) ? 8'h1d : 8'h1c;
         default: days_in_month = 8'h1f;
      endcase
   endfunction

   function automatic logic [7:0] ind_read(input rtcia_state_t st, input logic [4:0] a);
      unique case (a)
         IA_HTH: ind_read = st.hth;
         IA_SEC: ind_read = st.sec;
         IA_MIN: ind_read = st.min;
         IA_HOUR: ind_read = st.hour;
         IA_DAY: ind_read = st.day;
         IA_DATE: ind_read = st.date;
         IA_MONTH: ind_read = st.month;
         IA_YEAR: ind_read = st.year;
         IA_INTERVAL_LENGTH_VALUE: ind_read = st.interval_length_value;
         IA_AL_SEC: ind_read = st.alSec;
         IA_AL_MIN: ind_read = st.alMin;
         IA_AL_HOUR: ind_read = st.alHour;
         IA_AL_DAY: ind_read = st.alDay;
         IA_AL_DATE: ind_read = st.alDate;
         default: ind_read = RST_BYTE;
      endcase
   endfunction

   rtcia_prescaler rtcia_prescaler_i (
      .clk(clk),
      .rst(rst),
      .xtalTick(xtalTick),
      .trimSum(9'($signed(s_reg.nomTrim)) + 9'($signed(tempTrimIn))),
      .tick128(tick128),
      .hthTick(hthTick)
   );

   // Calendar carries, all from the crystal domain
   assign secCarry = hthTick && (s_reg.hth == MAX_HTH);
   assign minCarry = secCarry && (s_reg.sec == MAX_SEC);
   assign hourCarry = minCarry && (s_reg.min == MAX_SEC);

   always_comb begin
      unique case (s_reg.timebase)
         2'b00: tbTick = tick128;
         2'b01: tbTick = secCarry;
         2'b10: tbTick = minCarry;
         2'b11: tbTick = hourCarry;
      endcase
   end

   // All enabled fields equal; nothing enabled never matches
   assign alarmMatch = (s_reg.alEn != 5'h00) &&
      (!s_reg.alEn[4] || (s_reg.date == s_reg.alDate)) &&
      (!s_reg.alEn[3] || (s_reg.day == s_reg.alDay)) &&
      (!s_reg.alEn[2] || (s_reg.hour == s_reg.alHour)) &&
      (!s_reg.alEn[1] || (s_reg.min == s_reg.alMin)) &&
      (!s_reg.alEn[0] || (s_reg.sec == s_reg.alSec));

   assign ptrWrite = sfrWr && (sfrAddr == ADDR_PTR);
   assign ptrAddr = sfrWrData[PTR_ADDR_HI:0];
   assign indWrite = ptrWrite && sfrWrData[PTR_WRITE_SELECT] && (s_reg.key == WRITE_KEY);

   always_comb begin
      s_next = s_reg;
      s_next.chk = secCarry;
      // Time counters free-run regardless of power mode or system reset
      if (hthTick) begin
         s_next.hth = (s_reg.hth == MAX_HTH) ? RST_BYTE : s_reg.hth + 8'h01;
         if (secCarry) begin
            s_next.sec = (s_reg.sec == MAX_SEC) ? RST_BYTE : s_reg.sec + 8'h01;
         end
         if (minCarry) begin
            s_next.min = (s_reg.min == MAX_SEC) ? RST_BYTE : s_reg.min + 8'h01;
         end
         if (hourCarry) begin
            s_next.hour = (s_reg.hour == MAX_HOUR) ? RST_BYTE : s_reg.hour + 8'h01;
            if (s_reg.hour == MAX_HOUR) begin
               s_next.day = (s_reg.day == MAX_DAY) ? RST_BYTE : s_reg.day + 8'h01;
               if (s_reg.date == days_in_month(s_reg.month, s_reg.year)) begin
                  s_next.date = RST_DATE;
                  if (s_reg.month == MAX_MONTH) begin
                     s_next.month = RST_MONTH;
                     s_next.year = (s_reg.year == MAX_YEAR) ? RST_BYTE : s_reg.year + 8'h01;
                  end else begin
                     s_next.month = s_reg.month + 8'h01;
                  end
               end else begin
                  s_next.date = s_reg.date + 8'h01;
               end
            end
         end
      end
      // Pending configuration lands on the 128 Hz tick
      if (tick128) begin
         if (s_reg.cfgPend) begin
            s_next.timebase = s_reg.cfgSfr[CFG_TB_HI:CFG_TB_LO];
            s_next.oneShot = s_reg.cfgSfr[CFG_ONE_SHOT];
            s_next.interval_timer_enable = s_reg.cfgSfr[CFG_IT_EN];
            s_next.cfgPend = 1'b0;
         end
         if (s_reg.alEnPend) begin
            s_next.alEn = s_reg.alEnSfr;
            s_next.alEnPend = 1'b0;
         end
         if (s_reg.intvalPend) begin
            s_next.interval_length_value = s_reg.intvalSfr;
            s_next.intvalPend = 1'b0;
         end
      end
      // Interval timer
      if (!s_reg.interval_timer_enable) begin
         s_next.itCount = RST_BYTE;
         s_next.itDone = 1'b0;
      end else if (!s_reg.itDone && tbTick) begin
         if (s_reg.itCount + 8'h01 == s_reg.interval_length_value) begin
            s_next.itCount = RST_BYTE;
            s_next.itDone = s_reg.oneShot;
         end else begin
            s_next.itCount = s_reg.itCount + 8'h01;
         end
      end
      // Register writes from the core
      if (sfrWr) begin
         unique case (sfrAddr)
            ADDR_CONFIG: begin
               s_next.cfgSfr = sfrWrData;
               s_next.cfgPend = 1'b1;
               if (!sfrWrData[CFG_ALARM_FLAG]) begin
                  s_next.alarmFlag = 1'b0;
               end
               if (!sfrWrData[CFG_INT_FLAG]) begin
                  s_next.intFlag = 1'b0;
               end
            end
            ADDR_ALARM_EN: begin
               s_next.alEnSfr = sfrWrData[4:0];
               s_next.alEnPend = 1'b1;
            end
            ADDR_PTR: begin
               s_next.ptr = sfrWrData & 8'h9f;
               if (!sfrWrData[PTR_WRITE_SELECT]) begin
                  s_next.dat = ind_read(s_reg, ptrAddr);
               end
            end
            ADDR_PTR_DATA: s_next.dat = sfrWrData;
            ADDR_KEY: s_next.key = sfrWrData;
            ADDR_NOM_TRIM: s_next.nomTrim = sfrWrData;
            default: s_next.key = s_reg.key;
         endcase
      end
      if (indWrite) begin
         s_next.key = RST_BYTE;
         unique case (ptrAddr)
            IA_HTH: s_next.hth = s_reg.dat;
            IA_SEC: s_next.sec = s_reg.dat;
            IA_MIN: s_next.min = s_reg.dat;
            IA_HOUR: s_next.hour = s_reg.dat;
            IA_DAY: s_next.day = s_reg.dat;
            IA_DATE: s_next.date = s_reg.dat;
            IA_MONTH: s_next.month = s_reg.dat;
            IA_YEAR: s_next.year = s_reg.dat;
            IA_INTERVAL_LENGTH_VALUE: begin
               s_next.intvalSfr = s_reg.dat;
               s_next.intvalPend = 1'b1;
            end
            IA_AL_SEC: s_next.alSec = s_reg.dat;
            IA_AL_MIN: s_next.alMin = s_reg.dat;
            IA_AL_HOUR: s_next.alHour = s_reg.dat;
            IA_AL_DAY: s_next.alDay = s_reg.dat;
            IA_AL_DATE: s_next.alDate = s_reg.dat;
            default: s_next.key = RST_BYTE;
         endcase
      end
      // Flag sets come last so an event beats a clear in the same cycle
      if (s_reg.chk && alarmMatch) begin
         s_next.alarmFlag = 1'b1;
      end
      if (s_reg.interval_timer_enable && !s_reg.itDone && tbTick && (s_reg.itCount + 8'h01 == s_reg.interval_length_value)) begin
         s_next.intFlag = 1'b1;
      end
      // Read data, no key needed
      if (sfrRd) begin
         unique case (sfrAddr)
            ADDR_CONFIG: s_next.rdData = {1'b0, s_reg.alarmFlag, s_reg.cfgSfr[5:3],
               s_reg.intFlag, s_reg.cfgSfr[CFG_IT_EN], 1'b0};
            ADDR_ALARM_EN: s_next.rdData = {3'b000, s_reg.alEnSfr};
            ADDR_PTR: s_next.rdData = s_reg.ptr;
            ADDR_PTR_DATA: s_next.rdData = s_reg.dat;
            ADDR_KEY: s_next.rdData = s_reg.key;
            ADDR_NOM_TRIM: s_next.rdData = s_reg.nomTrim;
            ADDR_TEMP_TRIM: s_next.rdData = tempTrimIn;
            default: s_next.rdData = RST_BYTE;
         endcase
      end
      // Watchdog or pin reset: core-side registers only, counters kept
      if (sysReset) begin
         s_next.ptr = RST_BYTE;
         s_next.dat = RST_BYTE;
         s_next.key = RST_BYTE;
         s_next.nomTrim = RST_BYTE;
         s_next.rdData = RST_BYTE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.date <= RST_DATE;
         s_reg.month <= RST_MONTH;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sfrRdData = s_reg.rdData;
   assign rtcIrq = (s_reg.alarmFlag && alarmIrqEnable) || (s_reg.intFlag && intervalIrqEnable);

   // Helper: 128 Hz ticks seen while a config write is pending
   logic [1:0] pendTicks;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pendTicks <= 2'h0;
      end else if (!s_reg.cfgPend || (sfrWr && (sfrAddr == ADDR_CONFIG))) begin
         pendTicks <= 2'h0;
      end else if (tick128 && pendTicks != 2'h3) begin
         pendTicks <= pendTicks + 2'h1;
      end
   end

   property p_cfgLatency;
      @(posedge clk) disable iff (rst)
      pendTicks <= CFG_MAX_TICKS - 2'h1;
   endproperty
   a_cfgLatency: assert property (p_cfgLatency) else $error("config update too late");

   property p_noKeyNoWrite;
      @(posedge clk) disable iff (rst)
      ptrWrite && sfrWrData[PTR_WRITE_SELECT] && (s_reg.key != WRITE_KEY) && !hthTick &&
         (ptrAddr == IA_MIN) |=> s_reg.min == $past(s_reg.min);
   endproperty
   a_noKeyNoWrite: assert property (p_noKeyNoWrite) else $error("unkeyed write landed");

   property p_keyClear;
      @(posedge clk) disable iff (rst)
      indWrite |=> s_reg.key == RST_BYTE;
   endproperty
   a_keyClear: assert property (p_keyClear) else $error("key not cleared");

   property p_writeCopy;
      @(posedge clk) disable iff (rst)
      indWrite && (ptrAddr == IA_MIN) |=> s_reg.min == $past(s_reg.dat);
   endproperty
   a_writeCopy: assert property (p_writeCopy) else $error("indirect write lost");

   property p_readCopy;
      @(posedge clk) disable iff (rst)
      ptrWrite && !sfrWrData[PTR_WRITE_SELECT] && (ptrAddr == IA_HOUR) && !sysReset |=>
         s_reg.dat == $past(s_reg.hour);
   endproperty
   a_readCopy: assert property (p_readCopy) else $error("indirect read wrong");

   property p_itenClear;
      @(posedge clk) disable iff (rst)
      !s_reg.interval_timer_enable |=> s_reg.itCount == RST_BYTE;
   endproperty
   a_itenClear: assert property (p_itenClear) else $error("interval count kept");

   property p_oneShotHold;
      @(posedge clk) disable iff (rst)
      s_reg.itDone && s_reg.interval_timer_enable |=> s_reg.itCount == RST_BYTE;
   endproperty
   a_oneShotHold: assert property (p_oneShotHold) else $error("one-shot restarted");

   property p_alarmSet;
      @(posedge clk) disable iff (rst)
      s_reg.chk && alarmMatch |=> s_reg.alarmFlag;
   endproperty
   a_alarmSet: assert property (p_alarmSet) else $error("alarm flag missed");

   property p_irq;
      @(posedge clk) disable iff (rst)
      $rose(s_reg.intFlag) && intervalIrqEnable |-> rtcIrq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_hthWrap;
      @(posedge clk) disable iff (rst)
      secCarry && !indWrite |=> s_reg.hth == RST_BYTE;
   endproperty
   a_hthWrap: assert property (p_hthWrap) else $error("hundredths wrap wrong");
endmodule // rtcia_core

// File: test/rtcia_xtal_model.sv
`timescale 1ns/100ps
module rtcia_xtal_model #(
   parameter int DIVIDE = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Crystal tick, one clk cycle wide
   output logic xtalTick
);
   logic [7:0] divCount;

   // Shortened crystal period so that 128 Hz ticks fit in a short run
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         divCount <= 8'h00;
         xtalTick <= 1'b0;
      end else begin
         xtalTick <= (divCount == 8'(DIVIDE - 1));
         divCount <= (divCount == 8'(DIVIDE - 1)) ? 8'h00 : divCount + 8'h01;
      end
   end
endmodule // rtcia_xtal_model

// File: test/rtcia_core_test.sv
`timescale 1ns/100ps
module rtcia_core_test
   import rtcia_pkg::*;
;
   logic clk, rst, sysReset, xtalTick, sfrWr, sfrRd, rtcIrq;
   logic alarmIrqEnable, intervalIrqEnable;
   logic [7:0] sfrAddr, sfrWrData, sfrRdData, tempTrimIn, rdVal;
   int failCount, nTests;
   logic seen;
   logic [7:0] tMin, tHour;

   rtcia_xtal_model #(.DIVIDE(4)) rtcia_xtal_model_i (.clk(clk), .rst(rst), .xtalTick(xtalTick));

   rtcia_core rtcia_core_i (
      .clk(clk), .rst(rst), .sysReset(sysReset), .xtalTick(xtalTick),
      .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
      .sfrRdData(sfrRdData), .tempTrimIn(tempTrimIn), .alarmIrqEnable(alarmIrqEnable),
      .intervalIrqEnable(intervalIrqEnable), .rtcIrq(rtcIrq)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      nTests++;
      if (got !== exp) begin
         failCount++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfrAddr <= a;
      sfrWrData <= d;
      sfrWr <= 1'b1;
      @(posedge clk);
      sfrWr <= 1'b0;
   endtask

   task automatic rdReg(input logic [7:0] a);
      @(posedge clk);
      sfrAddr <= a;
      sfrRd <= 1'b1;
      @(posedge clk);
      sfrRd <= 1'b0;
      @(negedge clk);
      rdVal = sfrRdData;
   endtask

   // Keyed indirect write: key, data, then pointer with write select
   task automatic wrInd(input logic [4:0] a, input logic [7:0] d);
      wrReg(ADDR_KEY, WRITE_KEY);
      wrReg(ADDR_PTR_DATA, d);
      wrReg(ADDR_PTR, {3'b100, a});
   endtask

   task automatic rdInd(input logic [4:0] a);
      wrReg(ADDR_PTR, {3'b000, a});
      rdReg(ADDR_PTR_DATA);
   endtask

   // Time read on the fly; retried while the hundredths moved underneath
   task automatic rdTime();
      logic [7:0] first;
      logic same;
      same = 1'b0;
      for (int i = 0; i < 4 && !same; i++) begin
         rdInd(IA_HTH);
         first = rdVal;
         rdInd(IA_MIN);
         tMin = rdVal;
         rdInd(IA_HOUR);
         tHour = rdVal;
         rdInd(IA_HTH);
         same = (rdVal == first);
      end
   endtask

   // Poll a config bit, bounded by a number of polls
   task automatic waitCfg(input int bitPos, input int limit);
      seen = 1'b0;
      for (int i = 0; i < limit && seen !== 1'b1; i++) begin
         rdReg(ADDR_CONFIG);
         seen = rdVal[bitPos];
         if (seen !== 1'b1) repeat (60) @(posedge clk);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", nTests, failCount);
      if (failCount == 0 && nTests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #6000000;
      failCount++;
      $display("wrong value at %0t: watchdog expired", $time);
      summarize();
   end

   initial begin
      rst = 1'b1;
      sysReset = 1'b0;
      sfrAddr = 8'h00;
      sfrWrData = 8'h00;
      sfrWr = 1'b0;
      sfrRd = 1'b0;
      tempTrimIn = 8'h5a;
      alarmIrqEnable = 1'b0;
      intervalIrqEnable = 1'b1;
      failCount = 0;
      nTests = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // Direct registers
      rdReg(ADDR_CONFIG);
      chk(rdVal, 8'h00, "config after reset");
      rdReg(ADDR_KEY);
      chk(rdVal, 8'h00, "key after reset");
      wrReg(ADDR_TEMP_TRIM, 8'h11);
      rdReg(ADDR_TEMP_TRIM);
      chk(rdVal, 8'h5a, "temperature trim");
      wrReg(ADDR_NOM_TRIM, 8'h03);
      rdReg(ADDR_NOM_TRIM);
      chk(rdVal, 8'h03, "nominal trim");
      rdReg(8'ha0);
      chk(rdVal, 8'h00, "unmapped read");
      rdInd(IA_DATE);
      chk(rdVal, RST_DATE, "date after reset");
      $display("test registers done");
      // Keyed and unkeyed indirect writes
      wrInd(IA_MIN, 8'h05);
      rdReg(ADDR_KEY);
      chk(rdVal, 8'h00, "key after write");
      rdInd(IA_MIN);
      chk(rdVal, 8'h05, "minute written");
      wrReg(ADDR_PTR_DATA, 8'h07);
      wrReg(ADDR_PTR, 8'h83);
      rdInd(IA_MIN);
      chk(rdVal, 8'h05, "write without key");
      wrReg(ADDR_KEY, 8'ha7);
      wrReg(ADDR_PTR_DATA, 8'h07);
      wrReg(ADDR_PTR, 8'h83);
      rdReg(ADDR_KEY);
      chk(rdVal, 8'ha7, "wrong key kept");
      rdInd(IA_MIN);
      chk(rdVal, 8'h05, "write with wrong key");
      wrReg(ADDR_PTR, 8'h63);
      rdReg(ADDR_PTR);
      chk(rdVal, 8'h03, "pointer reserved bits");
      rdReg(ADDR_PTR_DATA);
      chk(rdVal, 8'h05, "read through reserved");
      $display("test key done");
      // About 750 crystal ticks give two or three hundredths
      wrInd(IA_HTH, 8'h00);
      repeat (3000) @(posedge clk);
      rdInd(IA_HTH);
      chk({7'h00, rdVal inside {8'h02, 8'h03}}, 8'h01, "hundredths count");
      $display("test counting done");
      // Watchdog or pin reset keeps time, clears trim
      wrInd(IA_HOUR, 8'h04);
      @(posedge clk);
      sysReset <= 1'b1;
      @(posedge clk);
      sysReset <= 1'b0;
      rdReg(ADDR_NOM_TRIM);
      chk(rdVal, 8'h00, "trim after system reset");
      rdTime();
      chk(tHour, 8'h04, "hour kept");
      chk(tMin, 8'h05, "minute kept");
      $display("test system reset done");
      // Repeating interval of three 1/128 s ticks
      wrInd(IA_INTERVAL_LENGTH_VALUE, 8'h03);
      wrReg(ADDR_CONFIG, 8'h02);
      rdReg(ADDR_CONFIG);
      chk(rdVal, 8'h02, "config written");
      waitCfg(CFG_INT_FLAG, 100);
      chk({7'h00, seen}, 8'h01, "interval flag");
      chk({7'h00, rtcIrq}, 8'h01, "irq with flag");
      @(posedge clk);
      intervalIrqEnable <= 1'b0;
      @(negedge clk);
      chk({7'h00, rtcIrq}, 8'h00, "irq disabled");
      @(posedge clk);
      intervalIrqEnable <= 1'b1;
      wrReg(ADDR_CONFIG, 8'h02);
      repeat (1500) @(posedge clk);
      rdReg(ADDR_CONFIG);
      chk(rdVal, 8'h02, "flag cleared");
      waitCfg(CFG_INT_FLAG, 100);
      chk({7'h00, seen}, 8'h01, "repeat flag");
      // One-shot, then re-arm by clearing enable
      wrReg(ADDR_CONFIG, 8'h0a);
      waitCfg(CFG_INT_FLAG, 100);
      chk({7'h00, seen}, 8'h01, "one-shot flag");
      wrReg(ADDR_CONFIG, 8'h0a);
      repeat (5000) @(posedge clk);
      rdReg(ADDR_CONFIG);
      chk(rdVal, 8'h0a, "no second one-shot");
      chk({7'h00, rtcIrq}, 8'h00, "no irq");
      wrReg(ADDR_CONFIG, 8'h08);
      repeat (2100) @(posedge clk);
      wrReg(ADDR_CONFIG, 8'h0a);
      waitCfg(CFG_INT_FLAG, 100);
      chk({7'h00, seen}, 8'h01, "re-armed flag");
      $display("test interval done");
      // Alarm: a minute mismatch blocks it, then a forced rollover matches
      wrReg(ADDR_CONFIG, 8'h00);
      wrInd(IA_SEC, 8'h10);
      wrInd(IA_AL_SEC, 8'h11);
      wrReg(ADDR_ALARM_EN, 8'h03);
      repeat (1100) @(posedge clk);
      wrInd(IA_HTH, 8'h63);
      repeat (1500) @(posedge clk);
      rdReg(ADDR_CONFIG);
      chk(rdVal, 8'h00, "alarm with minute mismatch");
      rdInd(IA_SEC);
      chk(rdVal, 8'h11, "second carry");
      wrInd(IA_SEC, 8'h10);
      wrInd(IA_INTERVAL_LENGTH_VALUE, 8'h01);
      wrReg(ADDR_ALARM_EN, 8'h01);
      wrReg(ADDR_CONFIG, 8'h12);
      alarmIrqEnable <= 1'b1;
      intervalIrqEnable <= 1'b0;
      repeat (1100) @(posedge clk);
      wrInd(IA_HTH, 8'h63);
      waitCfg(CFG_ALARM_FLAG, 100);
      chk({7'h00, seen}, 8'h01, "alarm flag");
      chk(rdVal, 8'h56, "second timebase interval");
      chk({7'h00, rtcIrq}, 8'h01, "alarm irq");
      wrReg(ADDR_CONFIG, 8'h12);
      rdReg(ADDR_CONFIG);
      chk(rdVal, 8'h12, "alarm flag cleared");
      $display("test alarm done");
      summarize();
   end
endmodule // rtcia_core_test
